// ### rtl/gpt_defs.svh
// Register addresses, field positions, reset values and counts of the timer block.
// Assumes inclusion by bare name from the design modules and the testbench.
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH

`define GPT_T0_LOAD_ADDR   32'hFFFF0300
`define GPT_T0_COUNT_ADDR  32'hFFFF0304
`define GPT_T0_CTRL_ADDR   32'hFFFF0308
`define GPT_T0_CLRI_ADDR   32'hFFFF030C
`define GPT_T1_LOAD_ADDR   32'hFFFF0320
`define GPT_T1_COUNT_ADDR  32'hFFFF0324
`define GPT_T1_CTRL_ADDR   32'hFFFF0328
`define GPT_T1_CLRI_ADDR   32'hFFFF032C
`define GPT_T1_CAP_ADDR    32'hFFFF0330

`define GPT_CTL_EN_BIT       7
`define GPT_CTL_PERIODIC_BIT 6
`define GPT_CTL_FMT_HI       5
`define GPT_CTL_FMT_LO       4
`define GPT_T0_PRE_HI        3
`define GPT_T0_PRE_LO        2
`define GPT_T1_PRE_HI        3
`define GPT_T1_PRE_LO        0
`define GPT_T1_UP_BIT        8
`define GPT_T1_CLK_HI        11
`define GPT_T1_CLK_LO        9
`define GPT_T1_EVT_HI        16
`define GPT_T1_EVT_LO        12
`define GPT_T1_CAPEN_BIT     17

`define GPT_T0_CTL_MASK    16'h00CC
`define GPT_T1_CTL_MASK    32'h0003FFFF
`define GPT_T0_LOAD_RST    16'h0000
`define GPT_T0_COUNT_RST   16'hFFFF
`define GPT_T0_CTL_RST     16'h0000
`define GPT_T1_LOAD_RST    32'h00000000
`define GPT_T1_COUNT_RST   32'hFFFFFFFF
`define GPT_T1_CTL_RST     32'h00000000
`define GPT_T1_CAP_RST     32'h00000000

`define GPT_T0_PRE_DIV16   2'b01
`define GPT_T0_PRE_DIV256  2'b10
`define GPT_T1_PRE_DIV16   4'b0100
`define GPT_T1_PRE_DIV256  4'b1000
`define GPT_T1_PRE_DIVMAX  4'b1111
`define GPT_DIV16_LAST     15
`define GPT_DIV256_LAST    255
`define GPT_T1_DIV_MAX     32768

`define GPT_TM_HR_HI   31
`define GPT_TM_HR_LO   24
`define GPT_TM_MIN_HI  21
`define GPT_TM_MIN_LO  16
`define GPT_TM_SEC_HI  13
`define GPT_TM_SEC_LO  8
`define GPT_TM_SUB_HI  6
`define GPT_TM_SUB_LO  0
`define GPT_TM_MASK    32'hFF3F3F7F
`define GPT_TM_SUB_MAX 7'h7F
`define GPT_TM_MS_MAX  6'h3B
`define GPT_TM_H24_MAX 8'h17
`define GPT_TM_H256_MAX 8'hFF

`endif

// ### rtl/gpt_pkg.sv
// Types shared by the timer block: count formats and clock sources.
// Assumes the constants header is on the include path.
`default_nettype none
package gpt_pkg;
    typedef enum logic [1:0] {
        GPT_FMT_BIN    = 2'b00,
        GPT_FMT_RSV    = 2'b01,
        GPT_FMT_HMS24  = 2'b10,
        GPT_FMT_HMS256 = 2'b11
    } gpt_fmt_t;

    typedef enum logic [2:0] {
        GPT_SRC_CORE  = 3'b000,
        GPT_SRC_XTAL  = 3'b001,
        GPT_SRC_GPIOA = 3'b010,
        GPT_SRC_GPIOB = 3'b011
    } gpt_clksrc_t;
endpackage
`default_nettype wire

// ### rtl/gpt_count_core.sv
// Counter core: free-running or periodic, up or down, binary or time format.
// Assumes tick is a one-cycle prescaled pulse on sys_clk and start follows a control write.
`default_nettype none
`include "gpt_defs.svh"
module gpt_count_core #(
    parameter int              W       = 16,
    parameter logic [W-1:0]    RST_VAL = '1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             start,
    input  wire logic             enable,
    input  wire logic             periodic,
    input  wire logic             count_up,
    input  wire gpt_pkg::gpt_fmt_t fmt,
    input  wire logic [W-1:0]     load_val,
    output logic      [W-1:0]     count_q,
    output logic                  event_q
);
    import gpt_pkg::*;

    generate
        if (W < 8 || W > 32) begin : g_bad_width
            $error("gpt_count_core: W must be 8 to 32");
        end
    endgenerate

    // =====================================================================
    // Time format stepping
    function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up,
                                            input logic [7:0] hmax);
        logic [7:0] h;
        logic [5:0] m;
        logic [5:0] s;
        logic [6:0] f;
        begin
            h = v[`GPT_TM_HR_HI:`GPT_TM_HR_LO];
            m = v[`GPT_TM_MIN_HI:`GPT_TM_MIN_LO];
            s = v[`GPT_TM_SEC_HI:`GPT_TM_SEC_LO];
            f = v[`GPT_TM_SUB_HI:`GPT_TM_SUB_LO];
            if (up) begin
                if (f < `GPT_TM_SUB_MAX) f = f + 7'h01;
                else begin
                    f = 7'h00;
                    if (s < `GPT_TM_MS_MAX) s = s + 6'h01;
                    else begin
                        s = 6'h00;
                        if (m < `GPT_TM_MS_MAX) m = m + 6'h01;
                        else begin
                            m = 6'h00;
                            h = (h >= hmax) ? 8'h00 : h + 8'h01;
                        end
                    end
                end
            end else begin
                if (f != 7'h00) f = f - 7'h01;
                else begin
                    f = `GPT_TM_SUB_MAX;
                    if (s != 6'h00) s = s - 6'h01;
                    else begin
                        s = `GPT_TM_MS_MAX;
                        if (m != 6'h00) m = m - 6'h01;
                        else begin
                            m = `GPT_TM_MS_MAX;
                            h = (h == 8'h00) ? hmax : h - 8'h01;
                        end
                    end
                end
            end
            tm_step = {h, 2'b00, m, 2'b00, s, 1'b0, f};
        end
    endfunction

    // =====================================================================
    // Next value and terminal detection
    logic          time_on;
    logic [7:0]    hmax;
    logic [W-1:0]  full_scale;
    logic [W-1:0]  nxt;
    logic [W-1:0]  term;
    logic [W-1:0]  ld;
    logic          reach;
    logic          hit;
    logic          step_en;

    // Time format only exists on a 32-bit counter
    assign time_on    = (W == 32) && (fmt == GPT_FMT_HMS24 || fmt == GPT_FMT_HMS256);
    assign hmax       = (fmt == GPT_FMT_HMS24) ? `GPT_TM_H24_MAX : `GPT_TM_H256_MAX;
    assign full_scale = time_on ? W'({hmax, 2'b00, `GPT_TM_MS_MAX, 2'b00, `GPT_TM_MS_MAX,
                                      1'b0, `GPT_TM_SUB_MAX}) : '1;
    assign nxt  = time_on ? W'(tm_step(32'(count_q), count_up, hmax)) :
                  (count_up ? count_q + 1'b1 : count_q - 1'b1);
    assign term = count_up ? full_scale : '0;
    assign ld   = time_on ? W'(32'(load_val) & `GPT_TM_MASK) : load_val;
    assign reach = (nxt == term);
    // Reload replaces the terminal step, so a period is load ticks down
    assign hit   = periodic && (reach || count_q == term);
    assign step_en = enable && tick && !start;

    always_ff @(posedge sys_clk) begin
        if (rst) count_q <= RST_VAL;
        else if (start && periodic) count_q <= ld;
        else if (step_en) count_q <= hit ? ld : nxt;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) event_q <= 1'b0;
        else event_q <= step_en && (reach || hit);
    end

    // =====================================================================
    // Checks
    property p_free_down_wrap;
        @(posedge sys_clk) disable iff (rst)
        step_en && !periodic && !count_up && !time_on && count_q == '0
        |=> count_q == '1;
    endproperty
    a_free_down_wrap: assert property (p_free_down_wrap)
        else $error("free-running down count did not wrap to maximum");

    property p_free_up_wrap;
        @(posedge sys_clk) disable iff (rst)
        step_en && !periodic && count_up && count_q == full_scale |=> count_q == '0;
    endproperty
    a_free_up_wrap: assert property (p_free_up_wrap)
        else $error("free-running up count did not wrap to minimum");

    property p_periodic_reload;
        @(posedge sys_clk) disable iff (rst)
        step_en && hit |=> count_q == $past(ld) && event_q;
    endproperty
    a_periodic_reload: assert property (p_periodic_reload)
        else $error("periodic count did not reload with an event");

    property p_down_step;
        @(posedge sys_clk) disable iff (rst)
        step_en && !hit && !count_up && !time_on |=> count_q == $past(count_q) - 1'b1;
    endproperty
    a_down_step: assert property (p_down_step)
        else $error("down count did not step by one");

    property p_hold_disabled;
        @(posedge sys_clk) disable iff (rst)
        !enable && !start |=> $stable(count_q) && !event_q;
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("disabled counter moved");
endmodule // gpt_count_core
`default_nettype wire

// ### rtl/gpt_timer_top.sv
// Timer block: a 16-bit RTOS timer and a 32-bit general-purpose timer behind APB.
// Assumes a synchronous APB master on sys_clk; clock pins arrive asynchronous.
//
// Added by the designer: register access over APB.
`default_nettype none
`include "gpt_defs.svh"
// Functional notes
// - Free down count wraps zero to maximum
// - Free up count wraps full scale to zero
// - Periodic count reloads load value at terminal
// - Period equals load, or full minus load
// - Count register readable anytime, undisturbed
// - Control write starts timer as configured
// - Interrupt raised at zero or full scale
// - Any write to clear register clears interrupt
// - Time format fields hours minutes seconds subseconds
// - Time layout applies to load and count
// - RTOS timer is 16-bit core-clock down counter
// - Control bit 7 enables timer, reset clear
// - Control bit 6 selects periodic mode
// - RTOS prescale codes divide 1, 16, 256
// - RTOS timer drives an ADC trigger
// - General timer 32-bit, four sources, four divides
// - Capture count on selected event's first assertion
// - General timer drives an ADC trigger
module gpt_timer_top #(
    parameter int T1_DIV_MAX = `GPT_T1_DIV_MAX
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xtal_32k_in,
    input  wire logic        gpio_clock_input_a,
    input  wire logic        gpio_clock_input_b,
    input  wire logic [31:0] irq_event_in,
    output logic             rtos_timer_irq,
    output logic             gp_timer_irq,
    output logic             rtos_timer_adc_trig,
    output logic             gp_timer_adc_trig
);
    import gpt_pkg::*;

    localparam int P1W = $clog2(T1_DIV_MAX);

    generate
        if (T1_DIV_MAX <= `GPT_DIV256_LAST + 1 || T1_DIV_MAX > `GPT_T1_DIV_MAX ||
            (T1_DIV_MAX & (T1_DIV_MAX - 1)) != 0) begin : g_bad_div
            $error("gpt_timer_top: T1_DIV_MAX must be a power of two, 512 to 32768");
        end
    endgenerate

    // =====================================================================
    // APB slave: zero wait states, read data registered in the setup cycle
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        setup;
    logic        wr;
    logic        mapped;
    logic [31:0] rdata;
    logic [31:0] wmask;

    logic [15:0] t0_load_q;
    logic [15:0] t0_ctl_q;
    logic [15:0] t0_count;
    logic        t0_start_q;
    logic        t0_evt;
    logic        t0_irq_q;
    logic [31:0] t1_load_q;
    logic [31:0] t1_ctl_q;
    logic [31:0] t1_count;
    logic [31:0] t1_cap_q;
    logic        t1_start_q;
    logic        t1_evt;
    logic        t1_irq_q;

    assign setup = psel && !penable;
    assign wr    = psel && penable && pready_q && pwrite;

    always_comb begin
        wmask = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end

    always_comb begin
        mapped = 1'b1;
        rdata  = 32'h00000000;
        case (paddr)
            `GPT_T0_LOAD_ADDR:  rdata = {16'h0000, t0_load_q};
            `GPT_T0_COUNT_ADDR: rdata = {16'h0000, t0_count};
            `GPT_T0_CTRL_ADDR:  rdata = {16'h0000, t0_ctl_q};
            `GPT_T0_CLRI_ADDR:  rdata = 32'h00000000;
            `GPT_T1_LOAD_ADDR:  rdata = t1_load_q;
            `GPT_T1_COUNT_ADDR: rdata = t1_count;
            `GPT_T1_CTRL_ADDR:  rdata = t1_ctl_q;
            `GPT_T1_CLRI_ADDR:  rdata = 32'h00000000;
            `GPT_T1_CAP_ADDR:   rdata = t1_cap_q;
            default:            mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite) prdata_q <= rdata;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // =====================================================================
    // Software registers; reserved control bits are never stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t0_load_q  <= `GPT_T0_LOAD_RST;
            t0_ctl_q   <= `GPT_T0_CTL_RST;
            t0_start_q <= 1'b0;
        end else begin
            t0_start_q <= wr && paddr == `GPT_T0_CTRL_ADDR;
            if (wr && paddr == `GPT_T0_LOAD_ADDR)
                t0_load_q <= (t0_load_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            if (wr && paddr == `GPT_T0_CTRL_ADDR)
                t0_ctl_q <= ((t0_ctl_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]))
                            & `GPT_T0_CTL_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t1_load_q  <= `GPT_T1_LOAD_RST;
            t1_ctl_q   <= `GPT_T1_CTL_RST;
            t1_start_q <= 1'b0;
        end else begin
            t1_start_q <= wr && paddr == `GPT_T1_CTRL_ADDR;
            if (wr && paddr == `GPT_T1_LOAD_ADDR)
                t1_load_q <= (t1_load_q & ~wmask) | (pwdata & wmask);
            if (wr && paddr == `GPT_T1_CTRL_ADDR)
                t1_ctl_q <= ((t1_ctl_q & ~wmask) | (pwdata & wmask)) & `GPT_T1_CTL_MASK;
        end
    end

    // =====================================================================
    // RTOS timer: core clock only, prescale 1/16/256
    logic [7:0] t0_pre_q;
    logic [7:0] t0_last;
    logic       t0_en;
    logic       t0_tick;

    assign t0_en = t0_ctl_q[`GPT_CTL_EN_BIT];

    always_comb begin
        case (t0_ctl_q[`GPT_T0_PRE_HI:`GPT_T0_PRE_LO])
            `GPT_T0_PRE_DIV16:  t0_last = 8'(`GPT_DIV16_LAST);
            `GPT_T0_PRE_DIV256: t0_last = 8'(`GPT_DIV256_LAST);
            default:            t0_last = 8'h00;
        endcase
    end

    assign t0_tick = t0_en && !t0_start_q && t0_pre_q >= t0_last;

    always_ff @(posedge sys_clk) begin
        if (rst || t0_start_q || !t0_en || t0_tick) t0_pre_q <= 8'h00;
        else t0_pre_q <= t0_pre_q + 8'h01;
    end

    gpt_count_core #(
        .W       (16),
        .RST_VAL (`GPT_T0_COUNT_RST)
    ) u_rtos_core (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .tick     (t0_tick),
        .start    (t0_start_q),
        .enable   (t0_en),
        .periodic (t0_ctl_q[`GPT_CTL_PERIODIC_BIT]),
        .count_up (1'b0),
        .fmt      (GPT_FMT_BIN),
        .load_val (t0_load_q),
        .count_q  (t0_count),
        .event_q  (t0_evt)
    );

    // =====================================================================
    // General timer clock sources; pin edges are sampled, so a source
    // must stay below a quarter of sys_clk to be counted reliably
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_rise;
    logic       t1_src_tick;
    logic [P1W-1:0] t1_pre_q;
    logic [P1W-1:0] t1_last;
    logic       t1_en;
    logic       t1_tick;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end else begin
            pin_s1_q <= {gpio_clock_input_b, gpio_clock_input_a, xtal_32k_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_s3_q;
    assign t1_en    = t1_ctl_q[`GPT_CTL_EN_BIT];

    always_comb begin
        case (gpt_clksrc_t'(t1_ctl_q[`GPT_T1_CLK_HI:`GPT_T1_CLK_LO]))
            GPT_SRC_CORE:  t1_src_tick = 1'b1;
            GPT_SRC_XTAL:  t1_src_tick = pin_rise[0];
            GPT_SRC_GPIOA: t1_src_tick = pin_rise[1];
            GPT_SRC_GPIOB: t1_src_tick = pin_rise[2];
            default:       t1_src_tick = 1'b0;
        endcase
    end

    always_comb begin
        case (t1_ctl_q[`GPT_T1_PRE_HI:`GPT_T1_PRE_LO])
            `GPT_T1_PRE_DIV16:  t1_last = P1W'(`GPT_DIV16_LAST);
            `GPT_T1_PRE_DIV256: t1_last = P1W'(`GPT_DIV256_LAST);
            `GPT_T1_PRE_DIVMAX: t1_last = P1W'(T1_DIV_MAX - 1);
            default:            t1_last = '0;
        endcase
    end

    assign t1_tick = t1_en && !t1_start_q && t1_src_tick && t1_pre_q >= t1_last;

    always_ff @(posedge sys_clk) begin
        if (rst || t1_start_q || !t1_en || t1_tick) t1_pre_q <= '0;
        else if (t1_src_tick) t1_pre_q <= t1_pre_q + 1'b1;
    end

    gpt_count_core #(
        .W       (32),
        .RST_VAL (`GPT_T1_COUNT_RST)
    ) u_gp_core (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .tick     (t1_tick),
        .start    (t1_start_q),
        .enable   (t1_en),
        .periodic (t1_ctl_q[`GPT_CTL_PERIODIC_BIT]),
        .count_up (t1_ctl_q[`GPT_T1_UP_BIT]),
        .fmt      (gpt_fmt_t'(t1_ctl_q[`GPT_CTL_FMT_HI:`GPT_CTL_FMT_LO])),
        .load_val (t1_load_q),
        .count_q  (t1_count),
        .event_q  (t1_evt)
    );

    // =====================================================================
    // Capture on the rising edge of the selected event; capture beats a
    // software write landing in the same cycle
    logic evt_sel;
    logic evt_prev_q;
    logic cap_fire;

    assign evt_sel  = irq_event_in[t1_ctl_q[`GPT_T1_EVT_HI:`GPT_T1_EVT_LO]];
    assign cap_fire = t1_ctl_q[`GPT_T1_CAPEN_BIT] && evt_sel && !evt_prev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) evt_prev_q <= 1'b0;
        else evt_prev_q <= evt_sel;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) t1_cap_q <= `GPT_T1_CAP_RST;
        else if (cap_fire) t1_cap_q <= t1_count;
        else if (wr && paddr == `GPT_T1_CAP_ADDR)
            t1_cap_q <= (t1_cap_q & ~wmask) | (pwdata & wmask);
    end

    // =====================================================================
    // Interrupt flags: terminal event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) t0_irq_q <= 1'b0;
        else if (t0_evt) t0_irq_q <= 1'b1;
        else if (wr && paddr == `GPT_T0_CLRI_ADDR) t0_irq_q <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) t1_irq_q <= 1'b0;
        else if (t1_evt) t1_irq_q <= 1'b1;
        else if (wr && paddr == `GPT_T1_CLRI_ADDR) t1_irq_q <= 1'b0;
    end

    assign rtos_timer_irq      = t0_irq_q;
    assign gp_timer_irq        = t1_irq_q;
    assign rtos_timer_adc_trig = t0_evt;
    assign gp_timer_adc_trig   = t1_evt;

    // =====================================================================
    // Checks
    property p_irq_set;
        @(posedge sys_clk) disable iff (rst)
        t0_evt |=> t0_irq_q;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("terminal event did not raise the interrupt");

    property p_irq_clear;
        @(posedge sys_clk) disable iff (rst)
        wr && paddr == `GPT_T1_CLRI_ADDR && !t1_evt |=> !t1_irq_q;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("clear write left the interrupt pending");

    property p_read_count;
        @(posedge sys_clk) disable iff (rst)
        setup && !pwrite && paddr == `GPT_T0_COUNT_ADDR
        |=> pready && prdata == {16'h0000, $past(t0_count)};
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("count read returned a wrong value");

    property p_capture;
        @(posedge sys_clk) disable iff (rst)
        cap_fire |=> t1_cap_q == $past(t1_count);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture register missed the event");

    property p_ctl_reserved;
        @(posedge sys_clk) disable iff (rst)
        ##1 (t0_ctl_q & ~`GPT_T0_CTL_MASK) == 16'h0000 &&
            (t1_ctl_q & ~`GPT_T1_CTL_MASK) == 32'h00000000;
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved)
        else $error("reserved control bits are set");

    property p_t0_prescale;
        @(posedge sys_clk) disable iff (rst)
        t0_tick && t0_ctl_q[`GPT_T0_PRE_HI:`GPT_T0_PRE_LO] == `GPT_T0_PRE_DIV16 |=> !t0_tick;
    endproperty
    a_t0_prescale: assert property (p_t0_prescale)
        else $error("divide-by-16 prescaler ticked twice in a row");

    property p_t0_trig;
        @(posedge sys_clk) disable iff (rst)
        rtos_timer_adc_trig |=> !rtos_timer_adc_trig && rtos_timer_irq;
    endproperty
    a_t0_trig: assert property (p_t0_trig)
        else $error("trigger pulse longer than one cycle or no interrupt");

    property p_t1_trig;
        @(posedge sys_clk) disable iff (rst)
        gp_timer_adc_trig |-> $past(t1_en);
    endproperty
    a_t1_trig: assert property (p_t1_trig)
        else $error("trigger from a disabled general timer");
endmodule // gpt_timer_top
`default_nettype wire

// ### dv/gpt_irq_model.sv
// ADC trigger sink beside the timer block: measures trigger spacing.
// Assumes one-cycle trigger pulses on sys_clk.
`default_nettype none
module gpt_irq_model (
    input  wire logic sys_clk,
    input  wire logic trig,
    output int        gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // ==========
    // Trigger spacing, so period checks need no cycle guessing
    always @(posedge sys_clk) begin
        cnt <= trig ? 0 : cnt + 1;
        if (trig)
            gap <= cnt + 1;
    end
endmodule // gpt_irq_model
`default_nettype wire

// ### dv/gpt_timer_top_tb.sv
// Self-checking bench: APB reads and writes of both timers.
// Assumes zero-wait APB answers and trigger models on both timers.
`default_nettype none
`include "gpt_defs.svh"
module gpt_timer_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, ev = 0, prdata, d, dp;
    logic        pready, pslverr, e, irq0, irq1, trg0, trg1;
    int          g0, g1, n_mismatch = 0, total_checks = 0;
    int          div[4] = '{1, 16, 256, 1};
    logic [2:0]  xc = 3'h0;
    always #10 sys_clk = ~sys_clk;
    // Crystal stand-in: one rising edge every 8 cycles, well below a quarter of sys_clk
    always @(posedge sys_clk) xc <= xc + 3'h1;
    gpt_timer_top #(.T1_DIV_MAX(512)) dut (.sys_clk(sys_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xtal_32k_in(xc[2]), .gpio_clock_input_a(1'b0),
        .gpio_clock_input_b(1'b0), .irq_event_in(ev), .rtos_timer_irq(irq0),
        .gp_timer_irq(irq1), .rtos_timer_adc_trig(trg0), .gp_timer_adc_trig(trg1));
    gpt_irq_model m0 (.sys_clk(sys_clk), .trig(trg0), .gap(g0));
    gpt_irq_model m1 (.sys_clk(sys_clk), .trig(trg1), .gap(g1));
    // ==========
    // Bus and check tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task end_sim;
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    // ==========
    // Tests
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        xfer(0, `GPT_T0_COUNT_ADDR, 0);
        chk(d, 32'h0000FFFF);
        xfer(0, `GPT_T0_CTRL_ADDR, 0);
        chk(d, 32'h0);
        xfer(1, `GPT_T0_CTRL_ADDR, 32'h0000FF33);
        xfer(0, `GPT_T0_CTRL_ADDR, 0);
        chk(d, 32'h0);
        xfer(0, 32'hFFFF0310, 0);
        chk({d[30:0], e}, 32'h1);
        xfer(1, `GPT_T0_LOAD_ADDR, 3);
        for (int i = 0; i < 4; i++) begin
            xfer(1, `GPT_T0_CTRL_ADDR, 32'hC0 | (i << 2));
            repeat (6 * div[i] + 20) @(posedge sys_clk);
            chk(g0, 3 * div[i]);
        end
        chk(irq0, 1'b1);
        xfer(1, `GPT_T0_CTRL_ADDR, 0);
        xfer(1, `GPT_T0_CLRI_ADDR, 32'h5A);
        @(posedge sys_clk);
        chk(irq0, 1'b0);
        xfer(1, `GPT_T0_CTRL_ADDR, 32'h80);
        repeat (10) @(posedge sys_clk);
        xfer(0, `GPT_T0_COUNT_ADDR, 0);
        dp = d;
        xfer(0, `GPT_T0_COUNT_ADDR, 0);
        chk(dp[15:8], 8'hFF);
        chk(dp - d, 32'h3);
        chk(irq0, 1'b1);
        xfer(0, `GPT_T1_COUNT_ADDR, 0);
        chk(d, 32'hFFFFFFFF);
        xfer(1, `GPT_T1_LOAD_ADDR, 32'hFFFFFFF0);
        xfer(1, `GPT_T1_CTRL_ADDR, 32'h000201C0);
        repeat (50) @(posedge sys_clk);
        chk(g1, 32'd15);
        ev <= 32'h1;
        repeat (3) @(posedge sys_clk);
        xfer(0, `GPT_T1_CAP_ADDR, 0);
        chk(d[31:4], 28'hFFFFFFF);
        // Stop first so no terminal event can race the clear
        xfer(1, `GPT_T1_CTRL_ADDR, 32'h00000100);
        xfer(1, `GPT_T1_CLRI_ADDR, 32'hA5);
        @(posedge sys_clk);
        chk(irq1, 1'b0);
        xfer(1, `GPT_T1_CTRL_ADDR, 32'h00000180);
        repeat (20) @(posedge sys_clk);
        xfer(0, `GPT_T1_COUNT_ADDR, 0);
        chk(d[31:6], 26'h0);
        chk(irq1, 1'b1);
        // Time format: 0:00:01:00 counting down, crystal source, divide 256
        xfer(1, `GPT_T1_LOAD_ADDR, 32'h00000100);
        xfer(1, `GPT_T1_CTRL_ADDR, 32'h000002E8);
        repeat (2500) @(posedge sys_clk);
        xfer(0, `GPT_T1_COUNT_ADDR, 0);
        dp = d;
        xfer(0, `GPT_T1_COUNT_ADDR, 0);
        if (d !== dp) xfer(0, `GPT_T1_COUNT_ADDR, 0);
        chk(d, 32'h0000007F);
        end_sim();
    end
endmodule // gpt_timer_top_tb
`default_nettype wire
